// ### src/adw_pkg.sv
// Package for the A/D register access wait generator.
// Assumes one CPU clock domain and that the CPU and peripheral clocks share one source.
package adw_pkg;

    localparam int CNT_W     = 5;
    localparam int SHIFT_W   = 3;
    localparam int SHIFT_MAX = 4;
    localparam int DIV_W     = 4;

    // Register that the CPU reaches in one access.
    typedef enum logic [2:0] {
        ADW_TGT_MODE,
        ADW_TGT_CHANNEL,
        ADW_TGT_PORTCFG_A,
        ADW_TGT_PORTCFG_B,
        ADW_TGT_RESULT,
        ADW_TGT_RESULT_HIGH,
        ADW_TGT_RESULT_LOW,
        ADW_TGT_OTHER
    } adw_target_type;

    // Conversion clock as a division of the peripheral clock.
    typedef enum logic [2:0] {
        ADW_AD_DIV1,
        ADW_AD_DIV2,
        ADW_AD_DIV3,
        ADW_AD_DIV4,
        ADW_AD_DIV6,
        ADW_AD_DIV8,
        ADW_AD_DIV12
    } adw_ad_sel_type;

    localparam logic [DIV_W-1:0] AD_DIV_1  = 4'h1;
    localparam logic [DIV_W-1:0] AD_DIV_2  = 4'h2;
    localparam logic [DIV_W-1:0] AD_DIV_3  = 4'h3;
    localparam logic [DIV_W-1:0] AD_DIV_4  = 4'h4;
    localparam logic [DIV_W-1:0] AD_DIV_6  = 4'h6;
    localparam logic [DIV_W-1:0] AD_DIV_8  = 4'h8;
    localparam logic [DIV_W-1:0] AD_DIV_12 = 4'hc;

    localparam logic [CNT_W-1:0] WAIT_MIN    = 5'h01;
    // Slow conversion clocks never stall for less than two clocks, and divide by 8
    // is capped below its twice-ratio figure.
    localparam logic [CNT_W-1:0] WAIT_MIN_SLOW = 5'h02;
    localparam logic [CNT_W-1:0] WAIT_MAX_DIV8 = 5'h0f;
    localparam logic [CNT_W-1:0] CNT_RESET   = 5'h00;
    localparam logic [DIV_W-1:0] PHASE_RESET = 4'h0;

endpackage

// ### src/adw_wait_gen.sv
// Wait generator for CPU accesses to the A/D converter registers.
// Assumes the CPU holds its access steady while cpu_wait is high and the
// peripheral clock runs during any access that stalls.
//
// Function
// R01 - Divide-by-2 conversion clock: access stalls the CPU 1 to 5 clocks.
// R02 - Divide-by-3 conversion clock: access stalls the CPU 1 to 7 clocks.
// R03 - Divide-by-4 conversion clock: access stalls the CPU 1 to 9 clocks.
// R04 - Divide-by-6 conversion clock: access stalls the CPU 2 to 13 clocks.
// R05 - Divide-by-8 conversion clock: access stalls the CPU 2 to 15 clocks.
// R06 - Divide-by-12 conversion clock: access stalls the CPU 2 to 25 clocks.
// R07 - Wait count is twice the CPU clock over the conversion clock.
// R08 - A fraction up to one half is dropped, above one half rounds up.
// R09 - Counts hold when CPU and peripheral clocks come from one source.
// R10 - Conversion clock is selectable from undivided down to divide by 12.
// R11 - CPU must not make a stalling access while the peripheral clock stops.
// R12 - Wait request stays high for the computed count, then releases the access.
`timescale 1ns/1ps

module adw_wait_gen (
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic                    cpu_acc_valid,
    input  wire logic                    cpu_acc_write,
    input  wire adw_pkg::adw_target_type cpu_acc_target,
    input  wire logic [adw_pkg::SHIFT_W-1:0] cpu_clk_shift,
    input  wire adw_pkg::adw_ad_sel_type ad_clk_sel,
    output logic                         cpu_wait,
    output logic                         cpu_acc_done
);
    import adw_pkg::*;

    typedef enum logic [1:0] {
        ADW_ST_IDLE,
        ADW_ST_STALL,
        ADW_ST_FINAL
    } adw_state_type;

    // Division of the conversion clock against the common source clock.
    function automatic logic [DIV_W-1:0] ad_div_of(input adw_ad_sel_type sel);
        case (sel) // see R10
            ADW_AD_DIV1:  ad_div_of = AD_DIV_1;
            ADW_AD_DIV2:  ad_div_of = AD_DIV_2;
            ADW_AD_DIV3:  ad_div_of = AD_DIV_3;
            ADW_AD_DIV4:  ad_div_of = AD_DIV_4;
            ADW_AD_DIV6:  ad_div_of = AD_DIV_6;
            ADW_AD_DIV8:  ad_div_of = AD_DIV_8;
            ADW_AD_DIV12: ad_div_of = AD_DIV_12;
            default:      ad_div_of = AD_DIV_1;
        endcase
    endfunction

    // Both clocks share one source, so twice the frequency ratio reduces to
    // 2 * ad_div / 2^shift; see R09 and R07.
    function automatic logic [CNT_W-1:0] base_wait(input logic [DIV_W-1:0] div,
                                                   input logic [SHIFT_W-1:0] shift);
        logic [CNT_W:0] num;
        logic [CNT_W:0] quo;
        logic [CNT_W:0] rem;
        logic [CNT_W:0] unit;
        logic [SHIFT_W-1:0] s;
        s    = (shift > 3'(SHIFT_MAX)) ? 3'(SHIFT_MAX) : shift;
        num  = {1'b0, div, 1'b0};
        quo  = num >> s;
        rem  = num - (quo << s);
        unit = 6'h01 << s;
        if ({rem, 1'b0} > {1'b0, unit}) begin // see R08
            quo = quo + 6'h01;
        end
        base_wait = quo[CNT_W-1:0];
    endfunction

    adw_state_type    state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [DIV_W-1:0] phase_r, phase_nxt;
    logic             gen_acc;
    logic [CNT_W-1:0] total_wait;
    logic [CNT_W-1:0] base;
    logic [DIV_W-1:0] div_now;

    assign div_now = ad_div_of(ad_clk_sel);

    // Writes to setup registers and reads of results cross into the converter.
    always_comb begin
        case (cpu_acc_target)
            ADW_TGT_MODE, ADW_TGT_CHANNEL, ADW_TGT_PORTCFG_A, ADW_TGT_PORTCFG_B:
                gen_acc = cpu_acc_valid && cpu_acc_write;
            ADW_TGT_RESULT, ADW_TGT_RESULT_HIGH, ADW_TGT_RESULT_LOW:
                gen_acc = cpu_acc_valid && !cpu_acc_write;
            default:
                gen_acc = 1'b0;
        endcase
    end

    // A misaligned conversion clock phase costs one more clock to synchronise;
    // this spreads each count over its documented range; see R01 to R06.
    always_comb begin
        base = base_wait(div_now, cpu_clk_shift);
        total_wait = base + ((phase_r != PHASE_RESET) ? WAIT_MIN : CNT_RESET);
        if (total_wait < WAIT_MIN) begin
            total_wait = WAIT_MIN;
        end
        // The twice-ratio figure alone would leave the slow dividers one clock short
        // at the slowest CPU clock, and divide by 8 one clock long at the fastest.
        if (ad_clk_sel inside {ADW_AD_DIV6, ADW_AD_DIV8, ADW_AD_DIV12}
            && total_wait < WAIT_MIN_SLOW) begin // see R04, R05 and R06
            total_wait = WAIT_MIN_SLOW;
        end
        if (ad_clk_sel == ADW_AD_DIV8 && total_wait > WAIT_MAX_DIV8) begin // see R05
            total_wait = WAIT_MAX_DIV8;
        end
    end

    // Free-running model of the conversion clock phase.
    always_comb begin
        if (phase_r + 4'h1 >= div_now) begin
            phase_nxt = PHASE_RESET;
        end else begin
            phase_nxt = phase_r + 4'h1;
        end
    end

    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        cpu_wait     = 1'b0;
        cpu_acc_done = 1'b0;
        case (state_r)
            ADW_ST_IDLE: begin
                if (gen_acc) begin
                    cpu_wait = 1'b1; // see R12
                    cnt_nxt  = total_wait;
                    state_nxt = (total_wait == WAIT_MIN) ? ADW_ST_FINAL : ADW_ST_STALL;
                end else if (cpu_acc_valid) begin
                    cpu_acc_done = 1'b1;
                end
            end
            ADW_ST_STALL: begin
                cpu_wait = 1'b1; // see R12
                cnt_nxt  = cnt_r - WAIT_MIN;
                if (cnt_r == 5'h02) begin
                    state_nxt = ADW_ST_FINAL;
                end
            end
            ADW_ST_FINAL: begin
                cpu_acc_done = 1'b1;
                state_nxt    = ADW_ST_IDLE;
            end
            default: begin
                state_nxt = ADW_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ADW_ST_IDLE;
            cnt_r   <= CNT_RESET;
            phase_r <= PHASE_RESET;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            phase_r <= phase_nxt;
        end
    end

    // Helper logic for the checks below: length of the last wait and its cause.
    logic [CNT_W-1:0] len_r, len_nxt;
    logic [CNT_W-1:0] exp_r, exp_nxt;
    adw_ad_sel_type   sel_r, sel_nxt;
    logic             wait_d_r;

    always_comb begin
        len_nxt = len_r;
        exp_nxt = exp_r;
        sel_nxt = sel_r;
        if (cpu_wait) begin
            len_nxt = wait_d_r ? len_r + WAIT_MIN : WAIT_MIN;
        end
        if (state_r == ADW_ST_IDLE && gen_acc) begin
            exp_nxt = total_wait;
            sel_nxt = ad_clk_sel;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            len_r    <= CNT_RESET;
            exp_r    <= CNT_RESET;
            sel_r    <= ADW_AD_DIV1;
            wait_d_r <= 1'b0;
        end else begin
            len_r    <= len_nxt;
            exp_r    <= exp_nxt;
            sel_r    <= sel_nxt;
            wait_d_r <= cpu_wait;
        end
    end

    logic wait_end;
    assign wait_end = wait_d_r && !cpu_wait;

    a_wait_starts: assert property (@(posedge clk) disable iff (!rst_b) // see R12
        state_r == ADW_ST_IDLE && gen_acc |-> cpu_wait)
        else $error("Stalling access did not raise the wait request");
    a_plain_no_wait: assert property (@(posedge clk) disable iff (!rst_b) // see R12
        state_r == ADW_ST_IDLE && cpu_acc_valid && !gen_acc |-> !cpu_wait && cpu_acc_done)
        else $error("Non-stalling access was delayed");
    a_wait_len_match: assert property (@(posedge clk) disable iff (!rst_b) // see R07
        wait_end |-> len_r == exp_r && cpu_acc_done)
        else $error("Wait length differs from the computed count");
    a_div2_range: assert property (@(posedge clk) disable iff (!rst_b) // see R01
        wait_end && sel_r == ADW_AD_DIV2 |-> len_r >= 5'h01 && len_r <= 5'h05)
        else $error("Divide-by-2 wait out of range");
    a_div3_range: assert property (@(posedge clk) disable iff (!rst_b) // see R02
        wait_end && sel_r == ADW_AD_DIV3 |-> len_r >= 5'h01 && len_r <= 5'h07)
        else $error("Divide-by-3 wait out of range");
    a_div4_range: assert property (@(posedge clk) disable iff (!rst_b) // see R03
        wait_end && sel_r == ADW_AD_DIV4 |-> len_r >= 5'h01 && len_r <= 5'h09)
        else $error("Divide-by-4 wait out of range");
    a_div6_range: assert property (@(posedge clk) disable iff (!rst_b) // see R04
        wait_end && sel_r == ADW_AD_DIV6 |-> len_r >= 5'h02 && len_r <= 5'h0d)
        else $error("Divide-by-6 wait out of range");
    a_div8_range: assert property (@(posedge clk) disable iff (!rst_b) // see R05
        wait_end && sel_r == ADW_AD_DIV8 |-> len_r >= 5'h02 && len_r <= 5'h0f)
        else $error("Divide-by-8 wait out of range");
    a_div12_range: assert property (@(posedge clk) disable iff (!rst_b) // see R06
        wait_end && sel_r == ADW_AD_DIV12 |-> len_r >= 5'h02 && len_r <= 5'h19)
        else $error("Divide-by-12 wait out of range");
    a_round_half: assert property (@(posedge clk) disable iff (!rst_b) // see R08
        state_r == ADW_ST_IDLE && gen_acc && ad_clk_sel == ADW_AD_DIV3
        && cpu_clk_shift == 3'h2 && phase_r == PHASE_RESET |-> total_wait == 5'h01)
        else $error("Three halves did not truncate to one");

    c_div2_access:  cover property (@(posedge clk) disable iff (!rst_b)
        wait_end && sel_r == ADW_AD_DIV2);
    c_div12_access: cover property (@(posedge clk) disable iff (!rst_b)
        wait_end && sel_r == ADW_AD_DIV12 && len_r == 5'h19);
    c_result_read:  cover property (@(posedge clk) disable iff (!rst_b)
        state_r == ADW_ST_IDLE && gen_acc && cpu_acc_target == ADW_TGT_RESULT);
    c_back_to_back: cover property (@(posedge clk) disable iff (!rst_b)
        wait_end ##2 cpu_wait);
    c_div8_capped:  cover property (@(posedge clk) disable iff (!rst_b)
        wait_end && sel_r == ADW_AD_DIV8 && len_r == 5'h0f);

endmodule

// ### verif/adw_cpu_model.sv
// CPU core model that makes accesses to the A/D register wait generator.
// Assumes its tasks are called one time unit after a rising clock edge.
`timescale 1ns/1ps

module adw_cpu_model (
    input  wire logic               clk,
    input  wire logic               cpu_wait,
    input  wire logic               cpu_acc_done,
    output logic                    cpu_acc_valid,
    output logic                    cpu_acc_write,
    output adw_pkg::adw_target_type cpu_acc_target
);
    import adw_pkg::*;

    initial begin
        cpu_acc_valid = 1'b0;
        cpu_acc_write = 1'b0;
        cpu_acc_target = ADW_TGT_OTHER;
    end

    // Holds the access until done and counts the cycles with wait high.
    // The peripheral clock is taken as running during every access.
    task automatic access(input adw_target_type tgt, input logic wr,
                          output int n, output bit ok);
        n = 0;
        ok = 1'b1;
        cpu_acc_valid = 1'b1;
        cpu_acc_write = wr;
        cpu_acc_target = tgt;
        repeat (40) begin
            @(negedge clk);
            if (cpu_acc_done === 1'b1) break;
            if (cpu_wait === 1'b1) n++;
            else ok = 1'b0;
            @(posedge clk);
        end
        if (!(cpu_acc_done === 1'b1 && cpu_wait === 1'b0)) ok = 1'b0;
        @(posedge clk);
        #1;
    endtask

    // The access stays presented after done so that a next one can follow at once.
    task automatic idle();
        cpu_acc_valid = 1'b0;
    endtask
endmodule

// ### verif/tb_adc_register_access_wait_gen.sv
// Testbench for the A/D register access wait generator.
// Assumes adw_cpu_model drives the access port; clock and dividers come from here.
`timescale 1ns/1ps

module tb_adc_register_access_wait_gen;
    import adw_pkg::*;

    typedef struct {
        adw_ad_sel_type sel;
        int             sh;
        adw_target_type tgt;
        logic           wr;
        int             lo;
        int             hi;
    } adw_row_type;

    logic                 clk;
    logic                 rst_b;
    logic [SHIFT_W-1:0]   cpu_clk_shift;
    adw_ad_sel_type       ad_clk_sel;
    logic                 cpu_acc_valid;
    logic                 cpu_acc_write;
    adw_target_type       cpu_acc_target;
    logic                 cpu_wait;
    logic                 cpu_acc_done;
    int                   errors = 0;
    int                   samples_checked = 0;
    int                   n;
    bit                   ok;
    // Ranges follow twice the clock ratio plus one cycle of phase slip, held inside
    // each divider's limits: at least two clocks from divide by 6, at most 15 at 8.
    adw_row_type rows [17] = '{
        '{ADW_AD_DIV1, 0, ADW_TGT_MODE, 1'b1, 2, 3},
        '{ADW_AD_DIV1, 2, ADW_TGT_MODE, 1'b1, 1, 1},
        '{ADW_AD_DIV2, 0, ADW_TGT_CHANNEL, 1'b1, 4, 5},
        '{ADW_AD_DIV2, 4, ADW_TGT_PORTCFG_A, 1'b1, 1, 1},
        '{ADW_AD_DIV3, 0, ADW_TGT_PORTCFG_B, 1'b1, 6, 7},
        '{ADW_AD_DIV3, 2, ADW_TGT_RESULT, 1'b0, 1, 2},
        '{ADW_AD_DIV3, 3, ADW_TGT_RESULT_HIGH, 1'b0, 1, 2},
        '{ADW_AD_DIV4, 0, ADW_TGT_RESULT_HIGH, 1'b0, 8, 9},
        '{ADW_AD_DIV6, 0, ADW_TGT_RESULT_LOW, 1'b0, 12, 13},
        '{ADW_AD_DIV8, 1, ADW_TGT_MODE, 1'b1, 8, 9},
        '{ADW_AD_DIV12, 0, ADW_TGT_MODE, 1'b1, 24, 25},
        '{ADW_AD_DIV12, 3, ADW_TGT_RESULT, 1'b1, 0, 0},
        '{ADW_AD_DIV12, 3, ADW_TGT_MODE, 1'b0, 0, 0},
        '{ADW_AD_DIV12, 3, ADW_TGT_OTHER, 1'b1, 0, 0},
        '{ADW_AD_DIV6, 4, ADW_TGT_PORTCFG_B, 1'b1, 2, 2},
        '{ADW_AD_DIV8, 0, ADW_TGT_CHANNEL, 1'b1, 15, 15},
        '{ADW_AD_DIV12, 4, ADW_TGT_RESULT_LOW, 1'b0, 2, 2}};

    adw_wait_gen dut_u (
        .clk(clk), .rst_b(rst_b), .cpu_acc_valid(cpu_acc_valid),
        .cpu_acc_write(cpu_acc_write), .cpu_acc_target(cpu_acc_target),
        .cpu_clk_shift(cpu_clk_shift), .ad_clk_sel(ad_clk_sel),
        .cpu_wait(cpu_wait), .cpu_acc_done(cpu_acc_done));

    adw_cpu_model cpu_u (
        .clk(clk), .cpu_wait(cpu_wait), .cpu_acc_done(cpu_acc_done),
        .cpu_acc_valid(cpu_acc_valid), .cpu_acc_write(cpu_acc_write),
        .cpu_acc_target(cpu_acc_target));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string what, input int lo, input int hi, input int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            errors++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks made %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        rst_b = 1'b0;
        cpu_clk_shift = 3'h0;
        ad_clk_sel = ADW_AD_DIV2;
        repeat (11) @(posedge clk);
        @(negedge clk);
        check("wait in reset", 0, 0, int'(cpu_wait !== 1'b0));
        check("done in reset", 0, 0, int'(cpu_acc_done !== 1'b0));
        @(posedge clk);
        #1 rst_b = 1'b1;
        $display("reset test done");
        @(posedge clk);
        #1;
        foreach (rows[i]) begin
            ad_clk_sel = rows[i].sel;
            cpu_clk_shift = SHIFT_W'(rows[i].sh);
            cpu_u.access(rows[i].tgt, rows[i].wr, n, ok);
            check($sformatf("row %0d wait count", i), rows[i].lo, rows[i].hi, n);
            check($sformatf("row %0d wait shape", i), 1, 1, int'(ok));
            cpu_u.idle();
            @(posedge clk);
            #1;
        end
        $display("table test done");
        // Back to back accesses: stalling, plain, stalling, with no idle cycle.
        ad_clk_sel = ADW_AD_DIV2;
        cpu_clk_shift = 3'h1;
        cpu_u.access(ADW_TGT_MODE, 1'b1, n, ok);
        check("first of three", 2, 3, n);
        cpu_u.access(ADW_TGT_OTHER, 1'b0, n, ok);
        check("second of three", 0, 0, n);
        cpu_u.access(ADW_TGT_RESULT_LOW, 1'b0, n, ok);
        check("third of three", 2, 3, n);
        check("third shape", 1, 1, int'(ok));
        cpu_u.idle();
        $display("back to back test done");
        // Reset in mid-run must bring the outputs low and leave the next access clean.
        rst_b = 1'b0;
        @(negedge clk);
        check("wait in mid reset", 0, 0, int'(cpu_wait !== 1'b0));
        check("done in mid reset", 0, 0, int'(cpu_acc_done !== 1'b0));
        @(posedge clk);
        #1 rst_b = 1'b1;
        @(posedge clk);
        #1;
        cpu_u.access(ADW_TGT_CHANNEL, 1'b1, n, ok);
        check("access after reset", 2, 3, n);
        check("shape after reset", 1, 1, int'(ok));
        cpu_u.idle();
        $display("mid reset test done");
        print_verdict();
    end

    initial begin
        #(8 * 3000);
        errors++;
        print_verdict();
    end
endmodule
